/* File: spdtx_deframer.sv */
// Serial audio input deframer: three-wire stream to left/right samples
//
// Behaviour
// - Left-justified, I2S, right-justified; 16/18/20/24 bits
// - Right-justified: frame sync high means left
// - Sample data and sync on serial clock rise
// - Right-justified MSB after 16/14/12/8 clocks
// - Right-justified assumes 64 clocks per frame
// - I2S: frame sync low means left
// - I2S MSB one clock after sync edge
// - Left-justified: frame sync high means left
// - Left-justified MSB right at sync edge
`timescale 1ns/1ps
`default_nettype none
module spdtx_deframer
  import spdtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ser_clk,
  input wire logic ser_fs,
  input wire logic ser_data,
  input wire logic [1:0] fmt_sel,
  input wire logic [1:0] width_sel,
  output var logic [SPDTX_WORD_W-1:0] sample_data,
  output var logic sample_left,
  output var logic sample_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [SPDTX_SYNC_W-1:0] pins_s;
  logic sclk_s;
  logic fs_s;
  logic sd_s;

  spdtx_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in({ser_data, ser_fs, ser_clk}),
    .sync_out(pins_s)
  );

  // All three pins share the same latency, so data and sync stay aligned
  assign sclk_s = pins_s[SPDTX_SYNC_SCLK];
  assign fs_s = pins_s[SPDTX_SYNC_FS];
  assign sd_s = pins_s[SPDTX_SYNC_SD];

  ////////////////////////////////////////////////////////////////////////////
  // Word placement within a slot

  spdtx_fmt_t fmt;
  logic [5:0] word_len;
  logic [5:0] first_pos;
  logic [5:0] last_pos;
  logic [4:0] pad;

  // Same-domain levels, not synchronised: change them only between frames
  assign fmt = spdtx_fmt_t'(fmt_sel);

  always_comb begin
    case (spdtx_width_t'(width_sel))
      SPDTX_W16: begin
        word_len = SPDTX_LEN_16;
        pad = SPDTX_PAD_16;
      end
      SPDTX_W18: begin
        word_len = SPDTX_LEN_18;
        pad = SPDTX_PAD_18;
      end
      SPDTX_W20: begin
        word_len = SPDTX_LEN_20;
        pad = SPDTX_PAD_20;
      end
      default: begin
        word_len = SPDTX_LEN_24;
        pad = SPDTX_PAD_24;
      end
    endcase
  end

  // Format picks where the MSB sits
  always_comb begin
    case (fmt)
      SPDTX_FMT_I2S: first_pos = SPDTX_I2S_DELAY;
      // Right-justified so LSB ends at slot end
      SPDTX_FMT_RJ: begin
        case (spdtx_width_t'(width_sel))
          SPDTX_W16: first_pos = SPDTX_RJ_DELAY_16;
          SPDTX_W18: first_pos = SPDTX_RJ_DELAY_18;
          SPDTX_W20: first_pos = SPDTX_RJ_DELAY_20;
          default: first_pos = SPDTX_RJ_DELAY_24;
        endcase
      end
      // Left-justified, no delay; unused code behaves the same
      default: first_pos = SPDTX_LJ_DELAY;
    endcase
  end

  assign last_pos = 6'(first_pos + word_len - SPDTX_CNT_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // Slot tracking and capture

  logic sclk_prev_q;
  logic sclk_prev_d;
  logic fs_prev_q;
  logic fs_prev_d;
  logic [SPDTX_CNT_W-1:0] cnt_q;
  logic [SPDTX_CNT_W-1:0] cnt_d;
  logic slot_left_q;
  logic slot_left_d;
  logic [SPDTX_WORD_W-1:0] shift_q;
  logic [SPDTX_WORD_W-1:0] shift_d;
  logic [SPDTX_WORD_W-1:0] data_q;
  logic [SPDTX_WORD_W-1:0] data_d;
  logic left_q;
  logic left_d;
  logic valid_q;
  logic valid_d;

  logic sclk_rise;
  assign sclk_rise = sclk_s & ~sclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Slot position of the current serial clock rise

  logic fs_edge;
  logic chan_new;
  logic [SPDTX_CNT_W-1:0] pos_next;
  logic in_word;
  logic word_end;

  assign fs_edge = fs_s != fs_prev_q;

  // I2S left on low; others left on high
  assign chan_new = (fmt == SPDTX_FMT_I2S) ? ~fs_s : fs_s;

  // Saturate so an overlong slot never wraps into a false word
  always_comb begin
    if (fs_edge) begin
      pos_next = SPDTX_CNT_ZERO;
    end else if (cnt_q != SPDTX_CNT_MAX) begin
      pos_next = 6'(cnt_q + SPDTX_CNT_ONE);
    end else begin
      pos_next = cnt_q;
    end
  end

  // Only bits inside the word are kept
  assign in_word = (pos_next >= first_pos) && (pos_next <= last_pos);
  assign word_end = in_word && (pos_next == last_pos);

  ////////////////////////////////////////////////////////////////////////////
  // Capture

  always_comb begin
    logic [SPDTX_WORD_W-1:0] base;
    // A new slot must not inherit bits of one cut short
    base = fs_edge ? '0 : shift_q;
    sclk_prev_d = sclk_s;
    fs_prev_d = fs_prev_q;
    cnt_d = cnt_q;
    slot_left_d = slot_left_q;
    shift_d = shift_q;
    data_d = data_q;
    left_d = left_q;
    valid_d = 1'b0;
    // Counter, sync, shift and word registers update only on a serial clock rising edge
    if (sclk_rise) begin
      fs_prev_d = fs_s;
      cnt_d = pos_next;
      shift_d = base;
      if (fs_edge) begin
        slot_left_d = chan_new;
      end
      if (in_word) begin
        shift_d = {base[SPDTX_WORD_W-2:0], sd_s};
      end
      if (word_end) begin
        data_d = shift_d << pad;
        left_d = slot_left_d;
        valid_d = 1'b1;
      end
    end
  end

  // Counter idles saturated until the first sync edge is seen
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      cnt_q <= SPDTX_CNT_MAX;
      slot_left_q <= 1'b0;
      shift_q <= '0;
      data_q <= '0;
      left_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sclk_prev_d;
      fs_prev_q <= fs_prev_d;
      cnt_q <= cnt_d;
      slot_left_q <= slot_left_d;
      shift_q <= shift_d;
      data_q <= data_d;
      left_q <= left_d;
      valid_q <= valid_d;
    end
  end

  assign sample_data = data_q;
  assign sample_left = left_q;
  assign sample_valid = valid_q;

endmodule
`default_nettype wire

/* File: spdtx_pkg.sv */
// Constants and types for the serial audio input deframer
package spdtx_pkg;

  // Sample and slot geometry
  localparam int unsigned SPDTX_WORD_W = 24;
  localparam int unsigned SPDTX_CNT_W = 6;
  localparam logic [5:0] SPDTX_CNT_MAX = 6'h3f;
  localparam logic [5:0] SPDTX_CNT_ZERO = 6'h00;
  localparam logic [5:0] SPDTX_CNT_ONE = 6'h01;

  // Word widths in serial clocks
  localparam logic [5:0] SPDTX_LEN_16 = 6'h10;
  localparam logic [5:0] SPDTX_LEN_18 = 6'h12;
  localparam logic [5:0] SPDTX_LEN_20 = 6'h14;
  localparam logic [5:0] SPDTX_LEN_24 = 6'h18;

  // First bit position after a frame sync edge
  localparam logic [5:0] SPDTX_LJ_DELAY = 6'h00;
  localparam logic [5:0] SPDTX_I2S_DELAY = 6'h01;
  localparam logic [5:0] SPDTX_RJ_DELAY_16 = 6'h10;
  localparam logic [5:0] SPDTX_RJ_DELAY_18 = 6'h0e;
  localparam logic [5:0] SPDTX_RJ_DELAY_20 = 6'h0c;
  localparam logic [5:0] SPDTX_RJ_DELAY_24 = 6'h08;

  // Left shift that puts the MSB at bit 23 of the output word
  localparam logic [4:0] SPDTX_PAD_16 = 5'h08;
  localparam logic [4:0] SPDTX_PAD_18 = 5'h06;
  localparam logic [4:0] SPDTX_PAD_20 = 5'h04;
  localparam logic [4:0] SPDTX_PAD_24 = 5'h00;

  // Pins passing the synchroniser: serial clock, frame sync, data
  localparam int unsigned SPDTX_SYNC_W = 3;
  localparam int unsigned SPDTX_SYNC_SCLK = 0;
  localparam int unsigned SPDTX_SYNC_FS = 1;
  localparam int unsigned SPDTX_SYNC_SD = 2;

  typedef enum logic [1:0] {
    SPDTX_FMT_LJ = 2'b00,
    SPDTX_FMT_I2S = 2'b01,
    SPDTX_FMT_RJ = 2'b10
  } spdtx_fmt_t;

  typedef enum logic [1:0] {
    SPDTX_W16 = 2'b00,
    SPDTX_W18 = 2'b01,
    SPDTX_W20 = 2'b10,
    SPDTX_W24 = 2'b11
  } spdtx_width_t;

endpackage

/* File: spdtx_sync.sv */
// Two-flop synchroniser for the serial input pins
`timescale 1ns/1ps
`default_nettype none
module spdtx_sync
  import spdtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [SPDTX_SYNC_W-1:0] async_in,
  output var logic [SPDTX_SYNC_W-1:0] sync_out
);

  logic [SPDTX_SYNC_W-1:0] meta_q;
  logic [SPDTX_SYNC_W-1:0] meta_d;
  logic [SPDTX_SYNC_W-1:0] sync_q;
  logic [SPDTX_SYNC_W-1:0] sync_d;

  genvar gi;
  generate
    for (gi = 0; gi < SPDTX_SYNC_W; gi++) begin : g_bit
      // First stage feeds only the second stage
      always_comb begin
        meta_d[gi] = ce ? async_in[gi] : meta_q[gi];
        sync_d[gi] = ce ? meta_q[gi] : sync_q[gi];
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= meta_d[gi];
          sync_q[gi] <= sync_d[gi];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule
`default_nettype wire

/* File: spdtx_deframer_assertions.sv */
// Port checks for the deframer
`timescale 1ns/1ps
`default_nettype none
module spdtx_deframer_assertions
  import spdtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ser_clk,
  input wire logic ser_fs,
  input wire logic [1:0] fmt_sel,
  input wire logic [1:0] width_sel,
  input wire logic [SPDTX_WORD_W-1:0] sample_data,
  input wire logic sample_left,
  input wire logic sample_valid
);
  logic sc_q, fs_q;
  logic [5:0] pos_q, len;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  assign len = width_sel == SPDTX_W24 ? SPDTX_LEN_24 : SPDTX_LEN_16 + {3'h0, width_sel, 1'b0};
  // Slot position as the pins show it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sc_q, fs_q, pos_q} <= {2'b00, SPDTX_CNT_MAX};
    end else begin
      sc_q <= ser_clk;
      if (ser_clk && !sc_q) begin
        fs_q <= ser_fs;
        pos_q <= ser_fs != fs_q ? SPDTX_CNT_ZERO : pos_q + 6'(pos_q != SPDTX_CNT_MAX);
      end
    end
  end
  // Clock still high two edges back: fs and bit of that rise
  sequence bit_seen;
    $past(ser_clk, 2);
  endsequence
  valid_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("long valid");
  pad_zero_a: assert property (
    sample_valid |-> (sample_data[7:0] & (8'hff >> (len - 6'h10))) == 8'h00) else $error("pad");
  clk_rise_a: assert property (sample_valid |-> bit_seen)
    else $error("no rise");
  lr_chan_a: assert property (
    sample_valid && fmt_sel != SPDTX_FMT_I2S |-> sample_left == $past(ser_fs, 2)) else $error("chan");
  i2s_chan_a: assert property (
    sample_valid && fmt_sel == SPDTX_FMT_I2S |-> sample_left != $past(ser_fs, 2)) else $error("chan");
  lj_end_a: assert property (
    sample_valid && fmt_sel[0] == fmt_sel[1] |-> pos_q == len - 6'h01) else $error("lj end");
  i2s_end_a: assert property (
    sample_valid && fmt_sel == SPDTX_FMT_I2S |-> pos_q == len) else $error("i2s end");
  rj_end_a: assert property (
    sample_valid && fmt_sel == SPDTX_FMT_RJ |-> pos_q == 6'h1f) else $error("rj end");
  // Clock enable low freezes every output
  ce_hold_a: assert property (
    !ce |=> $stable(sample_data) && $stable(sample_left) && $stable(sample_valid)) else $error("ce hold");
endmodule
`default_nettype wire

/* File: spdtx_src_model.sv */
// Upstream three-wire audio source, 64 clocks a frame
`timescale 1ns/1ps
`default_nettype none
module spdtx_src_model
  import spdtx_pkg::*;
(
  output var logic ser_clk,
  output var logic ser_fs,
  output var logic ser_data
);
  initial {ser_clk, ser_fs, ser_data} = 3'h0;
  task automatic tick(input logic fs, input logic d);
    {ser_fs, ser_data} = {fs, d};
    #200 ser_clk = 1'b1;
    #200 ser_clk = 1'b0;
  endtask
  // Clock parks low after a frame; idle bits toggle so nothing stale
  task automatic send_frame(input logic [1:0] fmt, input logic [5:0] len, input logic [47:0] lr);
    logic lft;
    logic [5:0] fb;
    logic [23:0] w;
    lft = fmt != SPDTX_FMT_I2S;
    fb = lft ? (fmt == SPDTX_FMT_RJ ? 6'h20 - len : SPDTX_LJ_DELAY) : SPDTX_I2S_DELAY;
    #13;
    // Extra short slot for an fs edge
    if (ser_fs == lft) tick(!lft, !ser_data);
    for (int s = 0; s < 2; s++) begin
      w = s ? lr[23:0] : lr[47:24];
      for (int p = 0; p < 32; p++)
        tick(lft ^ s[0], p >= fb && p < fb + len ? w[23 - p + fb] : !ser_data);
    end
    ser_data = !ser_data;
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the deframer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spdtx_pkg::*;
  logic ref_clk, sys_rst, ce, ser_clk, ser_fs, ser_data, sample_left, sample_valid;
  logic [1:0] fmt_sel, width_sel;
  logic [SPDTX_WORD_W-1:0] sample_data;
  logic [47:0] lr;
  logic [24:0] q[$];
  int mismatches, cmp_count;
  spdtx_src_model src (.ser_clk, .ser_fs, .ser_data);
  spdtx_deframer DUT (.ref_clk, .sys_rst, .ce, .ser_clk, .ser_fs, .ser_data, .fmt_sel,
    .width_sel, .sample_data, .sample_left, .sample_valid);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [24:0] e, input logic [24:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d cmp %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Look mid-cycle, where registered outputs are settled
  always @(negedge ref_clk) begin
    if (sample_valid === 1'b1) begin
      chk("word", q.size() ? q.pop_front() : 'x, {sample_left, sample_data});
    end
  end
  initial begin
    logic [5:0] len;
    sys_rst = 1'b1;
    ce = 1'b1;
    {fmt_sel, width_sel} = 4'h0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h13c9c04b));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    // Every format code with every width; settle before switching
    for (int f = 0; f < 16; f++) begin
      repeat (8) @(negedge ref_clk);
      // Freeze a while in the gap; the checker wants outputs to hold
      ce = 1'b0;
      repeat (1 + $urandom % 4) @(negedge ref_clk);
      ce = 1'b1;
      {fmt_sel, width_sel} = 4'(f);
      len = width_sel == SPDTX_W24 ? SPDTX_LEN_24 : SPDTX_LEN_16 + {3'h0, width_sel, 1'b0};
      lr = {24'($urandom << (6'h18 - len)), 24'($urandom << (6'h18 - len))};
      q.push_back({1'b1, lr[47:24]});
      q.push_back({1'b0, lr[23:0]});
      src.send_frame(fmt_sel, len, lr);
    end
    for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge ref_clk);
    chk("left over", 25'h0, 25'(q.size()));
    conclude();
  end
endmodule
bind spdtx_deframer spdtx_deframer_assertions chk_i (.ref_clk, .sys_rst, .ce, .ser_clk, .ser_fs,
  .fmt_sel, .width_sel, .sample_data, .sample_left, .sample_valid);
`default_nettype wire
